// ### pkg/sbgt_pkg.sv
/*
 Constants of the sixteen-bit gated timer core: register offsets, field positions,
 reset values and timing counts.
 Assumes a single 250 MHz clock and an APB master with 32-bit data.
*/
// Function
// - Sixteen-bit up-counter as high and low bytes; byte writes load it directly.
// - Timer-on clear means off; gate enable makes counting follow the gate.
// - Clock select with crystal enable picks system, instruction, sensing, pin or crystal.
// - System clock source advances four counts per instruction cycle.
// - External source counts its rising edges, synchronised or not.
// - Counter mode needs a falling edge before the first counted rising edge.
// - Prescaler divides by 1, 2, 4 or 8 and is hidden from software.
// - Any count byte write clears the hidden prescaler.
// - Crystal enable starts the crystal oscillator, which keeps running in sleep.
// - Sync disable leaves the external clock unsynchronised.
// - Asynchronous external counting continues in sleep; overflow can wake.
// - Switching sync mode may drop or add one increment.
// - Rollover from FFFFh to 0000h sets the overflow flag, cleared by software.
// - Gated counting advances only while the gate matches the polarity.
package sbgt_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_LOW = 8'h00;
   localparam logic [7:0] OFS_HIGH = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_GATE = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_CLR = 8'h14;
   localparam logic [7:0] OFS_IEN = 8'h18;
   // ------------------------------------------------------------
   // Control and gate field positions and reset values
   // ------------------------------------------------------------
   localparam int CTRL_ON = 0;
   localparam int CTRL_SYNCDIS = 2;
   localparam int CTRL_OSCEN = 3;
   localparam int CTRL_PS_LO = 4;
   localparam int CTRL_CS_LO = 6;
   localparam int GATE_POL = 6;
   localparam int GATE_EN = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] GATE_RESET = 8'h00;
   // ------------------------------------------------------------
   // Clock select codes, timing and status bit position
   // ------------------------------------------------------------
   localparam logic [1:0] CS_INSTR = 2'h0;
   localparam logic [1:0] CS_SYS = 2'h1;
   localparam logic [1:0] CS_EXT = 2'h2;
   localparam logic [1:0] CS_SENSE = 2'h3;
   localparam int INSTR_DIV = 4;
   localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
   localparam int STAT_OVF = 0;
endpackage

// ### pkg/sbgt_tick_if.sv
/*
 Carries the clock-source tick from the source selector to the counter.
 Assumes both ends run on pclk.
*/
interface sbgt_tick_if;
   logic tick;
   logic src_ext;
   modport src (output tick, output src_ext);
   modport dst (input tick, input src_ext);
endinterface

// ### rtl/sbgt_source.sv
/*
 Clock source selection and external edge detection for the timer core.
 Assumes external inputs are synchronous to pclk, as a free-running clock sample.
*/
module sbgt_source (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Configuration
   input wire logic [1:0] clock_select,
   input wire logic crystal_osc_enable,
   input wire logic sync_disable,
   input wire logic arm_clear,
   // Sources
   input wire logic external_count_pin,
   input wire logic sense_osc,
   input wire logic crystal_clk,
   // Tick out
   sbgt_tick_if.src tick_o
);
   logic [1:0] phase_r;
   logic s1_r, s2_r, prev_r, armed_r;
   logic ext_raw, ext_lvl, ext_rise, ext_fall, is_ext;

   // ------------------------------------------------------------
   // Selection
   // ------------------------------------------------------------
   assign is_ext = clock_select[1];
   assign ext_raw = (clock_select == sbgt_pkg::CS_SENSE) ? sense_osc :
                    crystal_osc_enable ? crystal_clk : external_count_pin;
   // Asynchronous mode bypasses the two-stage synchroniser; a mode switch may
   // therefore drop or add one edge.
   assign ext_lvl = sync_disable ? ext_raw : s2_r;
   assign ext_rise = ext_lvl & ~prev_r & armed_r;
   assign ext_fall = ~ext_lvl & prev_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= 2'h0;
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         prev_r <= 1'b0;
         armed_r <= 1'b0;
      end else begin
         phase_r <= phase_r + 2'h1;
         s1_r <= ext_raw;
         s2_r <= s1_r;
         prev_r <= ext_lvl;
         // A falling edge must be seen before the first counted rise.
         if (arm_clear) begin
            armed_r <= 1'b0;
         end else if (ext_fall) begin
            armed_r <= 1'b1;
         end
      end
   end

   always_comb begin
      tick_o.src_ext = is_ext;
      case (clock_select)
         sbgt_pkg::CS_SYS: tick_o.tick = 1'b1;
         sbgt_pkg::CS_INSTR: tick_o.tick = (phase_r == sbgt_pkg::INSTR_LAST);
         default: tick_o.tick = ext_rise;
      endcase
   end

   armed_after_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(armed_r) |-> $past(arm_clear))
      else $error("Arm dropped without cause.");
   instr_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clock_select == sbgt_pkg::CS_INSTR && tick_o.tick) |=> !tick_o.tick[*3])
      else $error("Instruction clock ticks too fast.");
endmodule

// ### rtl/sbgt_core.sv
/*
 Sixteen-bit gated timer core with APB registers, prescaler and overflow interrupt.
 Assumes an APB master on pclk and external sources sampled on pclk.
*/
// Our own choices: the APB interface to the registers and the address map.
module sbgt_core (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Sources and gate
   input wire logic external_count_pin,
   input wire logic sense_osc,
   input wire logic crystal_clk,
   input wire logic gate_in,
   input wire logic sleep,
   // Outputs
   output logic crystal_run,
   output logic overflow_pulse,
   output logic irq
);
   sbgt_tick_if tk ();

   logic [15:0] count_r, count_nxt;
   logic [7:0] ctrl_r, gate_r;
   logic [2:0] pre_r;
   logic stat_r, ien_r;
   logic [31:0] rdata_nxt;
   logic wr_en, rd_en, wr_low, wr_high, wr_ctrl, wr_gate, wr_clr, wr_ien;
   logic timer_on, gate_enable, gate_polarity, gate_ok, run, tick_pre;
   logic [1:0] prescale_select;
   logic [2:0] pre_mask;
   logic incr, ovf, sleep_hold, hit_map, arm_clear, on_prev_r;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;
   assign wr_low = wr_en & (paddr == sbgt_pkg::OFS_LOW);
   assign wr_high = wr_en & (paddr == sbgt_pkg::OFS_HIGH);
   assign wr_ctrl = wr_en & (paddr == sbgt_pkg::OFS_CTRL);
   assign wr_gate = wr_en & (paddr == sbgt_pkg::OFS_GATE);
   assign wr_clr = wr_en & (paddr == sbgt_pkg::OFS_CLR);
   assign wr_ien = wr_en & (paddr == sbgt_pkg::OFS_IEN);
   assign hit_map = (paddr <= sbgt_pkg::OFS_IEN) & (paddr[1:0] == 2'h0);

   // ------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------
   assign timer_on = ctrl_r[sbgt_pkg::CTRL_ON];
   assign prescale_select = ctrl_r[sbgt_pkg::CTRL_PS_LO +: 2];
   assign gate_enable = gate_r[sbgt_pkg::GATE_EN];
   assign gate_polarity = gate_r[sbgt_pkg::GATE_POL];
   assign gate_ok = ~gate_enable | (gate_in == gate_polarity);
   assign run = timer_on & gate_ok;
   // Only asynchronous external counting survives sleep.
   assign sleep_hold = sleep & ~(tk.src_ext & ctrl_r[sbgt_pkg::CTRL_SYNCDIS]);
   assign arm_clear = wr_low | wr_high | ~timer_on | (timer_on & ~on_prev_r);

   sbgt_source u_src (
      .pclk(pclk),
      .presetn(presetn),
      .clock_select(ctrl_r[sbgt_pkg::CTRL_CS_LO +: 2]),
      .crystal_osc_enable(ctrl_r[sbgt_pkg::CTRL_OSCEN]),
      .sync_disable(ctrl_r[sbgt_pkg::CTRL_SYNCDIS]),
      .arm_clear(arm_clear),
      .external_count_pin(external_count_pin),
      .sense_osc(sense_osc),
      .crystal_clk(crystal_clk),
      .tick_o(tk)
   );

   // ------------------------------------------------------------
   // Prescaler and counter
   // ------------------------------------------------------------
   assign pre_mask = 3'((4'h1 << prescale_select) - 4'h1);
   assign tick_pre = tk.tick & run & ~sleep_hold;
   assign incr = tick_pre & ((pre_r & pre_mask) == pre_mask);
   assign ovf = incr & (count_r == 16'hFFFF);
   assign count_nxt = wr_low ? {count_r[15:8], pwdata[7:0]} :
                      wr_high ? {pwdata[7:0], count_r[7:0]} :
                      incr ? count_r + 16'h0001 : count_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= 16'h0000;
         pre_r <= 3'h0;
         on_prev_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         on_prev_r <= timer_on;
         if (wr_low | wr_high) begin
            pre_r <= 3'h0;
         end else if (incr) begin
            pre_r <= 3'h0;
         end else if (tick_pre) begin
            pre_r <= pre_r + 3'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Registers and interrupt
   // ------------------------------------------------------------
   always_comb begin
      case (paddr)
         sbgt_pkg::OFS_LOW: rdata_nxt = {24'h000000, count_r[7:0]};
         sbgt_pkg::OFS_HIGH: rdata_nxt = {24'h000000, count_r[15:8]};
         sbgt_pkg::OFS_CTRL: rdata_nxt = {24'h000000, ctrl_r};
         sbgt_pkg::OFS_GATE: rdata_nxt = {24'h000000, gate_r};
         sbgt_pkg::OFS_STAT: rdata_nxt = {31'h00000000, stat_r};
         sbgt_pkg::OFS_IEN: rdata_nxt = {31'h00000000, ien_r};
         default: rdata_nxt = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= sbgt_pkg::CTRL_RESET;
         gate_r <= sbgt_pkg::GATE_RESET;
         stat_r <= 1'b0;
         ien_r <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         crystal_run <= 1'b0;
         overflow_pulse <= 1'b0;
         irq <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl_r <= pwdata[7:0];
         if (wr_gate) gate_r <= pwdata[7:0];
         if (wr_ien) ien_r <= pwdata[sbgt_pkg::STAT_OVF];
         // A rollover in the clearing cycle keeps the flag set.
         stat_r <= ovf | (stat_r & ~(wr_clr & pwdata[sbgt_pkg::STAT_OVF]));
         if (rd_en) prdata <= rdata_nxt;
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit_map;
         crystal_run <= ctrl_r[sbgt_pkg::CTRL_OSCEN];
         overflow_pulse <= ovf;
         irq <= (ovf | stat_r) & ien_r;
      end
   end

   write_loads_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_low |=> count_r[7:0] == $past(pwdata[7:0]))
      else $error("Low byte write not loaded.");
   off_holds_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!timer_on && !wr_low && !wr_high) |=> $stable(count_r))
      else $error("Counter moved while off.");
   gate_holds_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      (gate_enable && gate_in != gate_polarity && !wr_low && !wr_high)
      |=> $stable(count_r))
      else $error("Counter moved with gate closed.");
   sys_clock_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_r[sbgt_pkg::CTRL_CS_LO +: 2] == sbgt_pkg::CS_SYS && prescale_select == 2'h0
       && timer_on && !gate_enable
       && !sleep && $stable(ctrl_r) && !wr_low && !wr_high)
      |=> count_r == $past(count_r) + 16'h0001)
      else $error("System clock count rate wrong.");
   prescale_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_low || wr_high) |=> pre_r == 3'h0)
      else $error("Prescaler not cleared by write.");
   overflow_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ovf && !wr_low && !wr_high) |=> stat_r && count_r == 16'h0000)
      else $error("Overflow flag not set.");
   flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      (stat_r && !wr_clr) |=> stat_r)
      else $error("Overflow flag lost without clear.");
   prescale_div_a: assert property (@(posedge pclk) disable iff (!presetn)
      (incr && prescale_select == 2'h3) |=> (!incr || prescale_select != 2'h3)[*7])
      else $error("Increment before prescale terminal.");
   sleep_async_a: assert property (@(posedge pclk) disable iff (!presetn)
      (sleep_hold && !wr_low && !wr_high) |=> $stable(count_r))
      else $error("Synchronous counting during sleep.");
endmodule

// ### verif/sbgt_src_model.sv
/*
 Behavioural far side of the timer: count pin, sensing oscillator and crystal.
 Assumes pclk as time base; every source is a pclk-aligned level.
*/
module sbgt_src_model (
   // Clock
   input wire logic pclk,
   // Control
   input wire logic run,
   input wire logic crystal_run,
   // Sources
   output logic external_count_pin,
   output logic sense_osc,
   output logic crystal_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] ph = 4'h0;
   initial begin
      external_count_pin = 1'b0;
      sense_osc = 1'b0;
      crystal_clk = 1'b0;
   end
   // Pin and sensing sources stand low outside bursts; the crystal toggles whenever crystal_run is high.
   always @(posedge pclk) begin
      ph <= ph + 4'h1;
      external_count_pin <= run & ph[2];
      sense_osc <= run & ph[1];
      crystal_clk <= crystal_run & ph[3];
   end
endmodule

// ### verif/sixteen_bit_gated_timer_core_tb.sv
/*
 Self-checking bench of the timer core over APB with a source model.
 Assumes the core answers each transfer in the cycle after setup.
*/
module sixteen_bit_gated_timer_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, ext, sense, xtal, crystal_run, overflow_pulse, irq;
   logic gate_in = 1'b0;
   logic sleep = 1'b0;
   logic run = 1'b0;
   logic seen_ovf = 1'b0;
   logic [31:0] q;
   logic e;
   int mismatches = 0;
   int compares = 0;
   always #2 pclk = ~pclk;
   always @(posedge pclk) if (overflow_pulse === 1'b1) seen_ovf <= 1'b1;
   sbgt_core i_sbgt_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_count_pin(ext), .sense_osc(sense), .crystal_clk(xtal),
      .gate_in(gate_in), .sleep(sleep), .crystal_run(crystal_run),
      .overflow_pulse(overflow_pulse), .irq(irq));
   sbgt_src_model i_sbgt_src_model (.pclk(pclk), .run(run), .crystal_run(crystal_run),
      .external_count_pin(ext), .sense_osc(sense), .crystal_clk(xtal));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(string name, logic [31:0] got, logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      check("pready", n < 50, 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] ctl(logic [1:0] cs, logic [1:0] ps, logic osc, logic sd);
      return {24'h0, cs, ps, osc, sd, 2'b01};
   endfunction
   task automatic cnt(output int v);
      logic [7:0] lo;
      apb(1'b0, sbgt_pkg::OFS_LOW, 32'h0);
      lo = q[7:0];
      apb(1'b0, sbgt_pkg::OFS_HIGH, 32'h0);
      v = {q[7:0], lo};
   endtask
   task automatic load(logic [15:0] v);
      apb(1'b1, sbgt_pkg::OFS_LOW, {24'h0, v[7:0]});
      apb(1'b1, sbgt_pkg::OFS_HIGH, {24'h0, v[15:8]});
   endtask
   // Runs the timer for n cycles; write latency makes the span slightly longer.
   task automatic burst(logic [31:0] c, int n, output int v);
      apb(1'b1, sbgt_pkg::OFS_CTRL, c);
      repeat (n) @(posedge pclk);
      apb(1'b1, sbgt_pkg::OFS_CTRL, c & 32'hFE);
      cnt(v);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      apb(1'b0, sbgt_pkg::OFS_CTRL, 32'h0);
      check("ctrl reset", q, {24'h0, sbgt_pkg::CTRL_RESET});
      apb(1'b0, sbgt_pkg::OFS_GATE, 32'h0);
      check("gate reset", q, {24'h0, sbgt_pkg::GATE_RESET});
      apb(1'b1, 8'h1C, 32'hFF);
      check("unmapped err", e, 1'b1);
   endtask
   task automatic t_hold;
      int v;
      load(16'h3CA5);
      cnt(v);
      check("load", v, 32'h3CA5);
      apb(1'b1, sbgt_pkg::OFS_GATE, 32'hC0);
      burst(ctl(sbgt_pkg::CS_SYS, 2'h0, 1'b0, 1'b0) & 32'hFE, 20, v);
      check("off", v, 32'h3CA5);
      burst(ctl(sbgt_pkg::CS_SYS, 2'h0, 1'b0, 1'b0), 20, v);
      check("gate hold", v, 32'h3CA5);
   endtask
   task automatic t_rate;
      int v, x;
      apb(1'b1, sbgt_pkg::OFS_GATE, 32'h0);
      for (int i = 0; i < 8; i++) begin
         load(16'h0);
         x = ((i < 4) ? 66 : 66 / sbgt_pkg::INSTR_DIV) >> (i % 4);
         burst(ctl((i < 4) ? sbgt_pkg::CS_SYS : sbgt_pkg::CS_INSTR, 2'(i), 1'b0, 1'b0), 64, v);
         check("rate", v >= x - 3 && v <= x + 3, 1'b1);
      end
   endtask
   task automatic t_ext;
      int v, n;
      for (int i = 0; i < 6; i++) begin
         load(16'h0);
         n = 0;
         apb(1'b1, sbgt_pkg::OFS_CTRL, ctl(2'h0, 2'h0, i % 3 == 2, 1'b0) & 32'hFE);
         while (i % 3 == 2 && crystal_run !== 1'b1 && n++ < 20) @(posedge pclk);
         sleep <= (i >= 3);
         run <= 1'b1;
         burst(ctl((i % 3 == 1) ? sbgt_pkg::CS_SENSE : sbgt_pkg::CS_EXT, 2'h0, i % 3 == 2,
            i >= 3), 96, v);
         check("xtal run", crystal_run, i % 3 == 2);
         run <= 1'b0;
         sleep <= 1'b0;
         n = (i % 3 == 0) ? 12 : (i % 3 == 1) ? 24 : 6;
         check("ext count", v >= n - 3 && v <= n + 3, 1'b1);
      end
   endtask
   task automatic t_ovf;
      int v;
      apb(1'b1, sbgt_pkg::OFS_IEN, 32'h1);
      load(16'hFFFE);
      gate_in <= 1'b1;
      apb(1'b1, sbgt_pkg::OFS_GATE, 32'hC0);
      burst(ctl(sbgt_pkg::CS_SYS, 2'h0, 1'b0, 1'b0), 10, v);
      check("wrap", v >= 9 && v <= 15, 1'b1);
      apb(1'b0, sbgt_pkg::OFS_STAT, 32'h0);
      check("flag", q, 32'h1);
      check("pulse", seen_ovf, 1'b1);
      check("irq", irq, 1'b1);
      apb(1'b1, sbgt_pkg::OFS_IEN, 32'h0);
      repeat (2) @(posedge pclk);
      check("masked", irq, 1'b0);
      apb(1'b1, sbgt_pkg::OFS_IEN, 32'h1);
      apb(1'b1, sbgt_pkg::OFS_CLR, 32'h1);
      apb(1'b0, sbgt_pkg::OFS_STAT, 32'h0);
      check("cleared", q, 32'h0);
      check("irq low", irq, 1'b0);
   endtask
   task automatic t_mid;
      int v;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      cnt(v);
      check("count after reset", v, 32'h0);
      apb(1'b0, sbgt_pkg::OFS_IEN, 32'h0);
      check("ien after reset", q, 32'h0);
      check("irq after reset", irq, 1'b0);
   endtask
   // ------------------------------------------------------------
   // Sequence and verdict
   // ------------------------------------------------------------
   task automatic results;
      if (mismatches == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_hold;
      t_rate;
      t_ext;
      t_ovf;
      t_mid;
      results;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      results;
   end
endmodule
